// >>> common/bvc_consts.vh
// Constants for the boost voltage controller: offsets, fields, resets, timing
`ifndef BVC_CONSTS_VH
`define BVC_CONSTS_VH

// Clock rates in kHz
`define BVC_CLK_KHZ 50000
`define BVC_OSC_KHZ 20000

// Switching frequencies in kHz
`define BVC_FSW0_KHZ 312
`define BVC_FSW1_KHZ 625
`define BVC_FSW2_KHZ 1250

// Adaptive evaluation interval in microseconds
`define BVC_EVAL_US 10

// Voltage arithmetic in millivolts
`define BVC_LSB_MV 420
`define BVC_ABS_MAX_MV 43000
`define BVC_RANGE0_MV 7000
`define BVC_RANGE1_MV 10000
`define BVC_RANGE2_MV 13000
`define BVC_RANGE3_MV 16000

// Register byte offsets
`define BVC_OFF_CTRL 4'h0
`define BVC_OFF_VOLT 4'h4
`define BVC_OFF_LOOP 4'h8
`define BVC_OFF_STAT 4'hc

// Control register fields
`define BVC_CTRL_ADAPT 0
`define BVC_CTRL_RSEL 1
`define BVC_CTRL_FREQ_LO 2
`define BVC_CTRL_DRV2 4
`define BVC_CTRL_DRV3 5
`define BVC_CTRL_SPREAD 6

// Voltage register fields
`define BVC_VOLT_CODE_LO 0
`define BVC_VOLT_CEIL_LO 8
`define BVC_VOLT_RANGE_LO 16

// Loop register fields
`define BVC_LOOP_THR_LO 0
`define BVC_LOOP_HYST_LO 4
`define BVC_LOOP_UP_LO 8
`define BVC_LOOP_DN_LO 10
`define BVC_LOOP_STR_LO 12

// Reset values
`define BVC_CTRL_RST 7'h31
`define BVC_CODE_RST 7'h20
`define BVC_CEIL_RST 7'h40
`define BVC_LOOP_RST 18'h3f054

`endif

// >>> logic/bvc_boost_ctrl.v
// Boost voltage controller top: register slave, target loop, drivers
`timescale 1ns/100ps
`default_nettype none
`include "bvc_consts.vh"

module bvc_boost_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [5:0] stringBelowHeadroom,
  input wire [5:0] stringAboveWindow,
  input wire [8:0] freqSetResistorPeriod,
  output wire switchCycleStart,
  output wire [8:0] switchPeriod,
  output reg [2:0] driverEnable,
  output reg [6:0] boostTargetCode,
  output reg [15:0] boostTargetMv,
  output reg [3:0] stringHeadroomThreshold,
  output reg [2:0] headroomHysteresis,
  output reg [5:0] monitoredStrings
);

  localparam [1:0] ACT_HOLD = 2'b00;
  localparam [1:0] ACT_UP = 2'b01;
  localparam [1:0] ACT_DOWN = 2'b10;
  localparam [1:0] ACT_CLAMP = 2'b11;
  localparam integer ABS_MAX_I = `BVC_ABS_MAX_MV;
  localparam integer LSB_MV_I = `BVC_LSB_MV;
  localparam [16:0] ABS_MAX = ABS_MAX_I[16:0];
  localparam [9:0] LSB_MV = LSB_MV_I[9:0];

  // Stored configuration
  reg [6:0] ctrl_r;
  reg [6:0] boostVoltageCode_r;
  reg [6:0] boostVoltageCeiling_r;
  reg [1:0] boostMinRangeSel_r;
  reg [17:0] loop_r;
  // Loop state
  reg [6:0] target_r;
  reg [6:0] target_nxt;
  reg [1:0] action_r;
  reg [1:0] action_nxt;
  reg adaptPrev_r;
  // Bus state
  reg ack_r;

  wire adaptiveSelect = ctrl_r[`BVC_CTRL_ADAPT];
  wire freqResistorSelect = ctrl_r[`BVC_CTRL_RSEL];
  wire [1:0] switchingFreqCode = ctrl_r[`BVC_CTRL_FREQ_LO +: 2];
  wire secondDriverEnable = ctrl_r[`BVC_CTRL_DRV2];
  wire thirdDriverEnable = ctrl_r[`BVC_CTRL_DRV3];
  wire spreadEnable = ctrl_r[`BVC_CTRL_SPREAD];
  wire [3:0] thrField = loop_r[`BVC_LOOP_THR_LO +: 4];
  wire [2:0] hystField = loop_r[`BVC_LOOP_HYST_LO +: 3];
  wire [1:0] raiseStepField = loop_r[`BVC_LOOP_UP_LO +: 2];
  wire [1:0] targetLowerStep = loop_r[`BVC_LOOP_DN_LO +: 2];
  wire [5:0] stringEnablePattern = loop_r[`BVC_LOOP_STR_LO +: 6];
  wire evalTick;

  // Bus request decode
  wire busReq = avs_read | avs_write;
  wire busDone = busReq & ack_r;
  wire [1:0] regIdx = avs_address[3:2];

  // One wait state on every access
  assign avs_waitrequest = busReq & ~ack_r;

  // Range minimum in millivolts
  function [16:0] rangeMinMv;
    input [1:0] sel;
    reg [31:0] minFull;
    begin
      case (sel)
        2'b00: minFull = `BVC_RANGE0_MV;
        2'b01: minFull = `BVC_RANGE1_MV;
        2'b10: minFull = `BVC_RANGE2_MV;
        default: minFull = `BVC_RANGE3_MV;
      endcase
      rangeMinMv = minFull[16:0];
    end
  endfunction

  // Millivolts for a code on the selected range
  function [16:0] codeToMv;
    input [1:0] sel;
    input [7:0] code;
    reg [17:0] prod;
    begin
      prod = code * LSB_MV;
      codeToMv = rangeMinMv(sel) + prod[16:0];
    end
  endfunction

  // Per-string masking of comparator results
  wire [5:0] lowMasked;
  wire [5:0] highMasked;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : gStr
      assign lowMasked[gi] = stringBelowHeadroom[gi] & stringEnablePattern[gi];
      assign highMasked[gi] = stringAboveWindow[gi] & stringEnablePattern[gi];
    end
  endgenerate

  wire anyLow = |lowMasked;
  wire anyHigh = |highMasked;

  // Step sizes in code units
  wire [7:0] upAmt = {6'h00, raiseStepField} + 8'h01;
  wire [7:0] dnAmt = {6'h00, targetLowerStep} + 8'h01;

  // Effective ceiling: field value as stored, not capped by absolute range
  wire [6:0] ceilCode = boostVoltageCeiling_r;
  // Floor is the stored voltage code, held under ceiling
  wire [6:0] floorCode = (boostVoltageCode_r > ceilCode) ? ceilCode : boostVoltageCode_r;

  // Candidates for the next adaptive step
  wire [7:0] upCand = {1'b0, target_r} + upAmt;
  wire [7:0] dnFloorSum = {1'b0, floorCode} + dnAmt;
  wire [7:0] dnCand = {1'b0, target_r} - dnAmt;
  wire upOverAbs = codeToMv(boostMinRangeSel_r, upCand) > ABS_MAX;
  // Unclamped millivolts of the present target
  wire [16:0] targetMvFull = codeToMv(boostMinRangeSel_r, {1'b0, target_r});

  // Next target: manual tracks code, adaptive steps on evaluation
  always @* begin
    target_nxt = target_r;
    action_nxt = action_r;
    if (!adaptiveSelect) begin
      target_nxt = floorCode;
      action_nxt = ACT_HOLD;
    end else if (!adaptPrev_r) begin
      target_nxt = floorCode;
      action_nxt = ACT_HOLD;
    end else if (target_r > ceilCode) begin
      target_nxt = ceilCode;
      action_nxt = ACT_CLAMP;
    end else if (target_r < floorCode) begin
      target_nxt = floorCode;
      action_nxt = ACT_CLAMP;
    end else if (evalTick) begin
      if (anyLow) begin
        if (upCand > {1'b0, ceilCode}) begin
          target_nxt = ceilCode;
          action_nxt = ACT_CLAMP;
        end else if (upOverAbs) begin
          action_nxt = ACT_CLAMP;
        end else begin
          target_nxt = upCand[6:0];
          action_nxt = ACT_UP;
        end
      end else if (anyHigh) begin
        if ({1'b0, target_r} < dnFloorSum) begin
          target_nxt = floorCode;
          action_nxt = (target_r == floorCode) ? ACT_HOLD : ACT_DOWN;
        end else begin
          target_nxt = dnCand[6:0];
          action_nxt = ACT_DOWN;
        end
      end else begin
        action_nxt = ACT_HOLD;
      end
    end
  end

  // Target register and mode tracking
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= `BVC_CODE_RST;
      action_r <= ACT_HOLD;
      adaptPrev_r <= 1'b0;
    end else begin
      target_r <= target_nxt;
      action_r <= action_nxt;
      adaptPrev_r <= adaptiveSelect;
    end
  end

  // Configuration writes, taken when waitrequest is low
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `BVC_CTRL_RST;
      boostVoltageCode_r <= `BVC_CODE_RST;
      boostVoltageCeiling_r <= `BVC_CEIL_RST;
      boostMinRangeSel_r <= 2'b00;
      loop_r <= `BVC_LOOP_RST;
    end else if (busDone && avs_write) begin
      case (regIdx)
        2'd0: ctrl_r <= avs_writedata[6:0];
        2'd1: begin
          boostVoltageCode_r <= avs_writedata[`BVC_VOLT_CODE_LO +: 7];
          boostVoltageCeiling_r <= avs_writedata[`BVC_VOLT_CEIL_LO +: 7];
          boostMinRangeSel_r <= avs_writedata[`BVC_VOLT_RANGE_LO +: 2];
        end
        2'd2: loop_r <= avs_writedata[17:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Bus acknowledge and registered read data
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= busReq & ~ack_r;
      if (avs_read && !ack_r) begin
        case (regIdx)
          2'd0: avs_readdata <= {25'h0000000, ctrl_r};
          2'd1: avs_readdata <= {14'h0000, boostMinRangeSel_r, 1'b0,
                                 boostVoltageCeiling_r, 1'b0, boostVoltageCode_r};
          2'd2: avs_readdata <= {14'h0000, loop_r};
          default: avs_readdata <= {boostTargetMv, 4'h0, adaptiveSelect,
                                    1'b0, action_r, 1'b0, target_r};
        endcase
      end
    end
  end

  // Registered outputs toward power stage and comparators
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      driverEnable <= 3'b001;
      boostTargetCode <= 7'h00;
      boostTargetMv <= 16'h0000;
      stringHeadroomThreshold <= 4'h0;
      headroomHysteresis <= 3'h0;
      monitoredStrings <= 6'h00;
    end else begin
      driverEnable <= {thirdDriverEnable, secondDriverEnable, 1'b1};
      boostTargetCode <= target_r;
      boostTargetMv <= (targetMvFull > ABS_MAX) ? ABS_MAX[15:0] : targetMvFull[15:0];
      stringHeadroomThreshold <= thrField;
      headroomHysteresis <= hystField;
      monitoredStrings <= stringEnablePattern;
    end
  end

  // Switching period generation
  bvc_switch_timer uSwitch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .freqResistorSelect(freqResistorSelect),
    .switchingFreqCode(switchingFreqCode),
    .freqSetResistorPeriod(freqSetResistorPeriod),
    .spreadEnable(spreadEnable),
    .switchCycleStart_r(switchCycleStart),
    .switchPeriod_r(switchPeriod)
  );

  // Evaluation interval for the adaptive loop
  bvc_eval_timer uEval (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .runEnable(adaptiveSelect),
    .evalTick_r(evalTick)
  );

endmodule
`default_nettype wire

// >>> logic/bvc_eval_timer.v
// Periodic tick for the adaptive headroom evaluation
`timescale 1ns/100ps
`default_nettype none
`include "bvc_consts.vh"

module bvc_eval_timer (
  input wire clk_sys,
  input wire rst_n,
  input wire runEnable,
  output reg evalTick_r
);

  localparam integer EVAL_CYC_I = `BVC_EVAL_US * `BVC_CLK_KHZ / 1000;
  localparam [11:0] EVAL_CYC = EVAL_CYC_I[11:0];

  reg [11:0] count_r;

  // Count down the interval while the loop runs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= EVAL_CYC - 12'h001; // No evaluation on the first edge out of reset
      evalTick_r <= 1'b0;
    end else begin
      evalTick_r <= 1'b0;
      if (!runEnable) begin
        count_r <= EVAL_CYC - 12'h001;
      end else if (count_r == 12'h000) begin
        count_r <= EVAL_CYC - 12'h001;
        evalTick_r <= 1'b1;
      end else begin
        count_r <= count_r - 12'h001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/bvc_switch_timer.v
// Switching period generator with resistor or code select and spread spectrum
`timescale 1ns/100ps
`default_nettype none
`include "bvc_consts.vh"

module bvc_switch_timer (
  input wire clk_sys,
  input wire rst_n,
  input wire freqResistorSelect,
  input wire [1:0] switchingFreqCode,
  input wire [8:0] freqSetResistorPeriod,
  input wire spreadEnable,
  output reg switchCycleStart_r,
  output reg [8:0] switchPeriod_r
);

  localparam integer PER0_I = `BVC_CLK_KHZ / `BVC_FSW0_KHZ;
  localparam integer PER1_I = `BVC_CLK_KHZ / `BVC_FSW1_KHZ;
  localparam integer PER2_I = `BVC_CLK_KHZ / `BVC_FSW2_KHZ;
  localparam [8:0] PER0 = PER0_I[8:0];
  localparam [8:0] PER1 = PER1_I[8:0];
  localparam [8:0] PER2 = PER2_I[8:0];

  reg [8:0] count_r;
  reg [7:0] lfsr_r;
  reg [8:0] basePeriod;
  reg [8:0] period_nxt;

  // Base period from resistor or stored code
  always @* begin
    if (freqResistorSelect) begin
      basePeriod = (freqSetResistorPeriod < 9'h002) ? 9'h002 : freqSetResistorPeriod;
    end else begin
      case (switchingFreqCode)
        2'b00: basePeriod = PER0;
        2'b01: basePeriod = PER1;
        2'b10: basePeriod = PER2;
        default: basePeriod = PER0;
      endcase
    end
    period_nxt = basePeriod + (spreadEnable ? {6'h00, lfsr_r[2:0]} : 9'h000);
  end

  // Period counter and dither source
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 9'h000;
      lfsr_r <= 8'h01;
      switchCycleStart_r <= 1'b0;
      switchPeriod_r <= 9'h000;
    end else begin
      switchCycleStart_r <= 1'b0;
      if (count_r == 9'h000) begin
        count_r <= period_nxt - 9'h001;
        switchPeriod_r <= period_nxt;
        switchCycleStart_r <= 1'b1;
        lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      end else begin
        count_r <= count_r - 9'h001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/bvc_boost_chk.sv
// Port checker for bus timing, driver enables, switching and target limits
`timescale 1ns/100ps
`default_nettype none
module bvc_boost_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic switchCycleStart,
  input wire logic [8:0] switchPeriod,
  input wire logic [2:0] driverEnable,
  input wire logic [15:0] boostTargetMv,
  input wire logic [3:0] stringHeadroomThreshold,
  input wire logic [5:0] monitoredStrings
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Accepted transfers by register
  wire logic take = !avs_waitrequest && (avs_read || avs_write);
  wire logic wrCtrl = take && avs_write && avs_address[3:2] == 2'h0;
  wire logic wrLoop = take && avs_write && avs_address[3:2] == 2'h2;
  AST_ONE_WAIT: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  AST_DRV_BASE: assert property (driverEnable[0])
    else $error("first driver not enabled");
  AST_DRV_WRITE: assert property (
    wrCtrl |-> ##2 driverEnable[2:1] == $past(avs_writedata[5:4], 2))
    else $error("driver enables do not follow control word");
  AST_LOOP_COPY: assert property (
    wrLoop |-> ##2 monitoredStrings == $past(avs_writedata[17:12], 2)
      && stringHeadroomThreshold == $past(avs_writedata[3:0], 2))
    else $error("loop settings not passed to comparators");
  AST_MV_CAP: assert property (boostTargetMv <= 16'ha7f8)
    else $error("target above absolute maximum");
  AST_PULSE: assert property (switchCycleStart |=> !switchCycleStart)
    else $error("cycle start longer than one clock");
  AST_PERIOD_MIN: assert property (switchCycleStart |-> switchPeriod >= 9'h2)
    else $error("switching period below two clocks");
  AST_RSV_ZERO: assert property (
    take && avs_read && avs_address[3:2] == 2'h0 |-> avs_readdata[31:7] == 25'h0)
    else $error("reserved control bits read nonzero");
endmodule
bind bvc_boost_ctrl bvc_boost_chk uChk (.clk_sys, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .switchCycleStart,
  .switchPeriod, .driverEnable, .boostTargetMv, .stringHeadroomThreshold, .monitoredStrings);
`default_nettype wire

// >>> verif/bvc_boost_ctrl_tb.sv
// Self-checking bench for the boost voltage controller
`timescale 1ns/100ps
`default_nettype none
`include "bvc_consts.vh"
module bvc_boost_ctrl_tb;
  localparam int EVAL = `BVC_EVAL_US * `BVC_CLK_KHZ / 1000;
  localparam logic [31:0] SM = 32'hffff087f;
  localparam logic [31:0] AM = 32'hffffffff;
  logic clk_sys = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, lfsr = 32'h34dd, v, e;
  logic [8:0] freqSetResistorPeriod = 9'h64;
  logic [95:0] needMv = 96'h0;
  logic [5:0] openMask = 6'h0;
  logic [31:0] expQ[$], mskQ[$];
  logic [6:0] c1;
  int per[6] = '{160, 80, 40, 160, 0, 160};
  int numErrors = 0, samplesChecked = 0, cyc = 0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, switchCycleStart;
  wire logic [5:0] stringBelowHeadroom, stringAboveWindow, monitoredStrings;
  wire logic [8:0] switchPeriod;
  wire logic [2:0] driverEnable, headroomHysteresis;
  wire logic [6:0] boostTargetCode;
  wire logic [15:0] boostTargetMv;
  wire logic [3:0] stringHeadroomThreshold;
  bvc_boost_ctrl uut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .stringBelowHeadroom, .stringAboveWindow,
    .freqSetResistorPeriod, .switchCycleStart, .switchPeriod, .driverEnable, .boostTargetCode,
    .boostTargetMv, .stringHeadroomThreshold, .headroomHysteresis, .monitoredStrings);
  bvc_led_model uLed (.clk_sys, .boostTargetMv, .stringHeadroomThreshold, .headroomHysteresis,
    .needMv, .openMask, .stringBelowHeadroom, .stringAboveWindow);
  always #10 clk_sys = !clk_sys;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finalReport;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      $display("MISMATCH t=%0t timeout", $time);
      numErrors++;
      finalReport;
    end
  end
  // Read answers against the oldest noted expectation
  always @(posedge clk_sys) begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0 && expQ.size() > 0) begin
      check(avs_readdata & mskQ.pop_front(), expQ.pop_front());
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] stat(input int k, input int r, input logic ad);
    int mv;
    mv = `BVC_RANGE0_MV + 3000 * r + `BVC_LSB_MV * k;
    if (mv > `BVC_ABS_MAX_MV) mv = `BVC_ABS_MAX_MV;
    return {mv[15:0], 4'h0, ad, 4'h0, k[6:0]};
  endfunction
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    check(avs_waitrequest, 32'h0);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    expQ.push_back(x & m);
    mskQ.push_back(m);
    bus(1'h0, a, 32'h0);
  endtask
  task waitSw;
    int n;
    n = 0;
    do begin
      n++;
      @(posedge clk_sys);
    end while (switchCycleStart !== 1'h1 && n < 400);
    check(switchCycleStart, 32'h1);
  endtask
  task waitCode;
    logic [6:0] c;
    int n;
    c = boostTargetCode;
    n = 0;
    while (boostTargetCode === c && n < 2000) begin
      n++;
      @(posedge clk_sys);
    end
    check(boostTargetCode !== c, 32'h1);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    rd(`BVC_OFF_CTRL, 32'h31, AM);
    rd(`BVC_OFF_VOLT, 32'h4020, AM);
    rd(`BVC_OFF_LOOP, 32'h3f054, AM);
    rd(`BVC_OFF_STAT, stat(32, 0, 1'h1), SM);
    check(driverEnable, 32'h7);
    repeat (6) begin
      lfsr = nxt(lfsr);
      bus(1'h1, `BVC_OFF_CTRL, lfsr);
      bus(1'h1, `BVC_OFF_STAT, AM);
      rd(`BVC_OFF_CTRL, lfsr & 32'h7f, AM);
      rd(`BVC_OFF_STAT, stat(32, 0, lfsr[0]), SM);
      check(driverEnable, {lfsr[5:4], 1'h1});
    end
    // Manual target over ranges, random code and ceiling, then all ones
    bus(1'h1, `BVC_OFF_CTRL, 32'h30);
    for (int r = 0; r < 5; r++) begin
      lfsr = nxt(lfsr);
      v = r < 4 ? {14'h0, r[1:0], 1'h0, lfsr[14:8], 1'h0, lfsr[6:0]} : AM;
      bus(1'h1, `BVC_OFF_VOLT, v);
      rd(`BVC_OFF_VOLT, v & 32'h37f7f, AM);
      e = stat(v[6:0] < v[14:8] ? v[6:0] : v[14:8], v[17:16], 1'h0);
      rd(`BVC_OFF_STAT, e, SM);
      check({boostTargetMv, 9'h0, boostTargetCode}, e & 32'hffff007f);
    end
    // Switching period per code, resistor select over code, spread
    for (int f = 0; f < 6; f++) begin
      lfsr = nxt(lfsr);
      e = {23'h0, lfsr[7:0] | 8'h10};
      freqSetResistorPeriod <= e[8:0];
      bus(1'h1, `BVC_OFF_CTRL, f < 4 ? f << 2 : (f == 4 ? 32'h0a : 32'h40));
      repeat (2) waitSw;
      check(switchPeriod & (f == 5 ? 9'h1f8 : 9'h1ff), f == 4 ? e : per[f]);
    end
    // Adaptive loop settles inside the window
    needMv <= {6{16'h36b0}};
    bus(1'h1, `BVC_OFF_VOLT, 32'h2810);
    bus(1'h1, `BVC_OFF_CTRL, 32'h31);
    repeat (8 * EVAL) @(posedge clk_sys);
    rd(`BVC_OFF_STAT, stat(18, 0, 1'h1), SM);
    // Open string ignored while disabled, then climbs to the ceiling
    openMask <= 6'h20;
    bus(1'h1, `BVC_OFF_LOOP, 32'h1f254);
    repeat (4 * EVAL) @(posedge clk_sys);
    rd(`BVC_OFF_STAT, stat(18, 0, 1'h1), SM);
    bus(1'h1, `BVC_OFF_LOOP, 32'h3f254);
    waitCode;
    c1 = boostTargetCode;
    waitCode;
    check(boostTargetCode - c1, 32'h3);
    repeat (12 * EVAL) @(posedge clk_sys);
    rd(`BVC_OFF_STAT, stat(40, 0, 1'h1), SM);
    // Strings far above window step down to the floor
    openMask <= 6'h0;
    needMv <= 96'h0;
    bus(1'h1, `BVC_OFF_LOOP, 32'h3f854);
    waitCode;
    c1 = boostTargetCode;
    waitCode;
    check(c1 - boostTargetCode, 32'h3);
    repeat (12 * EVAL) @(posedge clk_sys);
    rd(`BVC_OFF_STAT, stat(16, 0, 1'h1), SM);
    finalReport;
  end
endmodule
`default_nettype wire

// >>> verif/bvc_led_model.sv
// Power stage and LED string comparator model for the boost controller
`timescale 1ns/100ps
`default_nettype none
module bvc_led_model #(parameter int UNIT_MV = 100) (
  input wire logic clk_sys,
  input wire logic [15:0] boostTargetMv,
  input wire logic [3:0] stringHeadroomThreshold,
  input wire logic [2:0] headroomHysteresis,
  input wire logic [95:0] needMv,
  input wire logic [5:0] openMask,
  output logic [5:0] stringBelowHeadroom,
  output logic [5:0] stringAboveWindow
);
  int pin, lo, hi;
  // Pin is boost output less string drop; an open pin never has headroom
  always @(posedge clk_sys) begin
    lo = stringHeadroomThreshold * UNIT_MV;
    hi = lo + headroomHysteresis * UNIT_MV;
    for (int i = 0; i < 6; i++) begin
      pin = boostTargetMv - needMv[i*16 +: 16];
      stringBelowHeadroom[i] <= openMask[i] || pin < lo;
      stringAboveWindow[i] <= !openMask[i] && pin > hi;
    end
  end
endmodule
`default_nettype wire
